/* inc/wspi_defines.svh */
// Numeric constants of the SPI slave transaction engine: codes, field positions, reset values.
// Assumes inclusion by bare name from the package and the slave engine module.
`ifndef WSPI_DEFINES_SVH
`define WSPI_DEFINES_SVH
`define WSPI_ST_READY 8'h58
`define WSPI_ST_BUSY 8'h54
`define WSPI_ST_FAIL 8'h52
`define WSPI_TOKEN 8'h55
`define WSPI_DUMMY 8'h00
`define WSPI_INIT_B0 8'h12
`define WSPI_INIT_B1 8'h4A
`define WSPI_INIT_B2 8'h5C
`define WSPI_REG_INTR 6'h00
`define WSPI_INTR_RST 8'h00
`define WSPI_INTR_FULL 0
`define WSPI_INTR_PEND 3
`define WSPI_C1_TYPE_HI 7
`define WSPI_C1_TYPE_LO 6
`define WSPI_C1_WRITE 5
`define WSPI_C1_MEMFR 4
`define WSPI_C1_FRAME 3
`define WSPI_C1_LONG 2
`define WSPI_TYPE_RW 2'h1
`define WSPI_TYPE_INIT 2'h0
`define WSPI_C2_MODE_HI 7
`define WSPI_C2_MODE_LO 6
`define WSPI_MODE_32 2'h1
`define WSPI_LEN_ZERO4 16'h0004
`define WSPI_ADDR_LAST 2'h3
`endif

/* inc/wspi_link_if.sv */
// Carrier between the system-clock core and the SPI-clock shifter.
// Assumes rx_byte is stable for a whole byte time after each rx_tgl change.
`timescale 1ns/1ps
interface wspi_link_if;
    logic [7:0] rx_byte; // Last byte taken from MOSI.
    logic rx_tgl; // Flips once per received byte.
    logic [7:0] tx_byte; // Byte the shifter loads for the next slot.
    modport phy(output rx_byte, output rx_tgl, input tx_byte);
    modport core(input rx_byte, input rx_tgl, output tx_byte);
endinterface : wspi_link_if

/* inc/wspi_pkg.sv */
// Types shared by the core and the link-side shifter of the SPI slave engine.
// Assumes the constants header is on the include path.
`include "wspi_defines.svh"
package wspi_pkg;
    // Transaction states; init states come first so they compare below the command states.
    typedef enum logic [3:0] {
        S_INIT0 = 4'h0, S_INIT1 = 4'h1, S_INIT2 = 4'h2, S_INITD = 4'h3,
        S_CMD1 = 4'h4, S_CMD2 = 4'h5, S_STAT = 4'h6, S_LENL = 4'h7,
        S_LENH = 4'h8, S_ADDR = 4'h9, S_WDATA = 4'hA, S_RWAIT = 4'hB,
        S_RDATA = 4'hC, S_REGR = 4'hD, S_REGW = 4'hE, S_DROP = 4'hF
    } wspi_state_t;
    // Whole state of the core on the system clock.
    typedef struct packed {
        logic cs_s1; logic cs_s2; logic tg_s1; logic tg_s2; logic tg_seen;
        wspi_state_t st; logic inited;
        logic [7:0] c1; logic [7:0] c2; logic [7:0] status;
        logic [15:0] len; logic [1:0] cnt; logic [31:0] addr; logic [7:0] tx_hold;
        logic wr_valid; logic [7:0] wr_data; logic rd_req; logic rd_take;
    } wspi_core_t;
    // Whole state of the shifter on the SPI clock.
    typedef struct packed {
        logic [2:0] bitcnt; logic [6:0] sr; logic [7:0] rx_byte; logic rx_tgl;
        logic [7:0] tx_cur;
    } wspi_phy_t;
endpackage : wspi_pkg

/* src/wspi_link_phy.sv */
// Byte shifter running on the host's SPI clock, mode 0, most significant bit first.
// Assumes chip select is high between frames; it clears the shifter asynchronously.
`timescale 1ns/1ps
module wspi_link_phy (
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    wspi_link_if.phy lnk
);
    wspi_pkg::wspi_phy_t r; // Registered shifter state.
    wspi_pkg::wspi_phy_t next_r; // Next shifter state.

    // Collect MOSI bits and reload the transmit byte at every byte boundary.
    always_comb begin
        next_r = r;
        next_r.bitcnt = r.bitcnt + 3'h1;
        if (r.bitcnt == 3'h7) begin
            // The core changes tx_byte only just after a byte boundary, so it is quiet here.
            next_r.rx_byte = {r.sr, spi_mosi_i};
            next_r.rx_tgl = ~r.rx_tgl;
            next_r.tx_cur = lnk.tx_byte;
        end else begin
            next_r.sr = {r.sr[5:0], spi_mosi_i};
        end
    end

    // The SPI clock stops outside frames, so chip select is the only way to clear this state.
    always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Bit seven of the current byte leaves first, as the core expects.
    assign spi_miso_o = r.tx_cur[~r.bitcnt];
    assign lnk.rx_byte = r.rx_byte;
    assign lnk.rx_tgl = r.rx_tgl;
endmodule : wspi_link_phy

/* src/wspi_spi_slave.sv */
// SPI slave transaction engine: init, frame and memory read and write, register access.
// Assumes the host keeps chip select high for at least four system clocks between frames.
// Contract
// - Command bytes in order, MSB first.
// - Write bytes go in ascending index order.
// - Frame write sets bit 3, no address.
// - Ready status after C1/C2 allows continuation.
// - Busy status makes host abandon and retry.
// - Failure status reports a failed transaction.
// - Read sends dummies, token, then data.
// - Read data lowest byte first, MSB first.
// - Frame read has no address phase.
// - Register read is two bytes, address 5:0.
// - Register write is two bytes plus data.
// - Status bit 0 shows buffer full.
// - Status bit 3 shows packet pending.
// - First byte fields: type, direction, kind, length.
// - Second byte bits 7:6 select data width.
// - Bytes four and five carry long length.
// - Nothing works before one init; repeats fail.
`timescale 1ns/1ps
`include "wspi_defines.svh"
module wspi_spi_slave #(
    parameter int unsigned LEN_W = 16 // Length counter width; the wire format fixes it.
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire logic busy_i,
    input wire logic buf_full_i,
    input wire logic pkt_pending_i,
    output logic ready_o,
    output logic xfer_frame_o,
    output logic xfer_wide_o,
    output logic [31:0] xfer_addr_o,
    output logic [15:0] xfer_len_o,
    output logic wr_valid_o,
    output logic [7:0] wr_data_o,
    output logic rd_req_o,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    output logic rd_take_o
);
    // The length fields are sixteen bits on the wire; no other width can be served.
    if (LEN_W != 16) begin : g_len_check
        $error("LEN_W must be 16");
    end

    wspi_link_if lnk (); // Carrier to the link-side shifter.
    wspi_pkg::wspi_core_t r; // Registered core state.
    wspi_pkg::wspi_core_t next_r; // Next core state.
    logic evt; // One received byte is ready to be handled.

    // Answer to the first command byte, chosen before the second byte has arrived.
    function automatic logic [7:0] cmd_status(input logic [7:0] c1, input logic busy,
                                              input logic full);
        logic [7:0] s;
        s = `WSPI_ST_READY;
        if (c1[`WSPI_C1_TYPE_HI:`WSPI_C1_TYPE_LO] != `WSPI_TYPE_RW) begin
            // A second init or a reserved type cannot be served.
            s = `WSPI_ST_FAIL;
        end else if (busy) begin
            s = `WSPI_ST_BUSY;
        end else if (c1[`WSPI_C1_WRITE] && c1[`WSPI_C1_MEMFR] && c1[`WSPI_C1_FRAME] && full) begin
            // A frame write into a full buffer would be lost, so it is refused.
            s = `WSPI_ST_BUSY;
        end
        return s;
    endfunction : cmd_status

    // Value returned by a register read; unknown addresses and reserved bits read zero.
    function automatic logic [7:0] reg_value(input logic [5:0] a, input logic full,
                                             input logic pend);
        logic [7:0] v;
        v = `WSPI_INTR_RST;
        if (a == `WSPI_REG_INTR) begin
            v[`WSPI_INTR_FULL] = full;
            v[`WSPI_INTR_PEND] = pend;
        end
        return v;
    endfunction : reg_value

    // State that follows the length phase of a memory or frame transaction.
    function automatic wspi_pkg::wspi_state_t after_len(input logic [7:0] c1,
                                                        input logic [15:0] len);
        wspi_pkg::wspi_state_t s;
        if (len == 16'h0000) begin
            s = wspi_pkg::S_DROP;
        end else if (!c1[`WSPI_C1_FRAME]) begin
            s = wspi_pkg::S_ADDR;
        end else if (c1[`WSPI_C1_WRITE]) begin
            s = wspi_pkg::S_WDATA;
        end else begin
            s = wspi_pkg::S_RWAIT;
        end
        return s;
    endfunction : after_len

    // A new byte counts only inside a frame; between frames the toggle is simply tracked.
    assign evt = (r.tg_s2 != r.tg_seen) && !r.cs_s2;

    // The byte prepared on arrival of byte k goes out in slot k+2, which is why each
    // answer is decided one byte ahead of the slot it occupies.
    always_comb begin
        next_r = r;
        next_r.cs_s1 = spi_cs_n_i;
        next_r.cs_s2 = r.cs_s1;
        next_r.tg_s1 = lnk.rx_tgl;
        next_r.tg_s2 = r.tg_s1;
        next_r.wr_valid = 1'b0;
        next_r.rd_take = 1'b0;
        if (r.cs_s2) begin
            // Between frames every transaction ends; init must be done within one frame.
            next_r.tg_seen = r.tg_s2;
            next_r.tx_hold = `WSPI_DUMMY;
            next_r.st = r.inited ? wspi_pkg::S_CMD1 : wspi_pkg::S_INIT0;
        end else if (evt) begin
            next_r.tg_seen = r.tg_s2;
            next_r.tx_hold = `WSPI_DUMMY;
            case (r.st)
                wspi_pkg::S_INIT0: begin
                    // Until init completes every other byte is ignored.
                    if (lnk.rx_byte == `WSPI_INIT_B0) begin
                        next_r.st = wspi_pkg::S_INIT1;
                    end
                end
                wspi_pkg::S_INIT1: begin
                    if (lnk.rx_byte == `WSPI_INIT_B1) begin
                        // Ready must be committed now to reach the dummy byte's slot.
                        next_r.tx_hold = `WSPI_ST_READY;
                        next_r.st = wspi_pkg::S_INIT2;
                    end else begin
                        next_r.st = wspi_pkg::S_INIT0;
                    end
                end
                wspi_pkg::S_INIT2: begin
                    next_r.st = (lnk.rx_byte == `WSPI_INIT_B2) ? wspi_pkg::S_INITD
                                                               : wspi_pkg::S_INIT0;
                end
                wspi_pkg::S_INITD: begin
                    // The dummy byte closes the init sequence.
                    next_r.inited = 1'b1;
                    next_r.st = wspi_pkg::S_CMD1;
                end
                wspi_pkg::S_CMD1: begin
                    next_r.c1 = lnk.rx_byte;
                    next_r.status = cmd_status(lnk.rx_byte, busy_i, buf_full_i);
                    next_r.tx_hold = cmd_status(lnk.rx_byte, busy_i, buf_full_i);
                    next_r.st = wspi_pkg::S_CMD2;
                end
                wspi_pkg::S_CMD2: begin
                    next_r.c2 = lnk.rx_byte;
                    // A register read puts its value in the slot after the status.
                    if (!r.c1[`WSPI_C1_MEMFR] && !r.c1[`WSPI_C1_WRITE]) begin
                        next_r.tx_hold = reg_value(lnk.rx_byte[5:0], buf_full_i,
                                                   pkt_pending_i);
                    end
                    next_r.st = wspi_pkg::S_STAT;
                end
                wspi_pkg::S_STAT: begin
                    // The host's byte in the status slot carries nothing.
                    next_r.cnt = 2'h0;
                    next_r.addr = 32'h0000_0000;
                    if (r.status != `WSPI_ST_READY) begin
                        next_r.st = wspi_pkg::S_DROP;
                    end else if (!r.c1[`WSPI_C1_MEMFR]) begin
                        next_r.st = r.c1[`WSPI_C1_WRITE] ? wspi_pkg::S_REGW
                                                         : wspi_pkg::S_REGR;
                    end else if (r.c1[`WSPI_C1_LONG]) begin
                        next_r.st = wspi_pkg::S_LENL;
                    end else begin
                        // Short length: code zero means four bytes.
                        next_r.len = (r.c1[1:0] == 2'h0) ? `WSPI_LEN_ZERO4
                                                         : {14'h0000, r.c1[1:0]};
                        next_r.st = after_len(r.c1, next_r.len);
                    end
                end
                wspi_pkg::S_LENL: begin
                    next_r.len[7:0] = lnk.rx_byte;
                    next_r.st = wspi_pkg::S_LENH;
                end
                wspi_pkg::S_LENH: begin
                    next_r.len[15:8] = lnk.rx_byte;
                    next_r.st = after_len(r.c1, {lnk.rx_byte, r.len[7:0]});
                end
                wspi_pkg::S_ADDR: begin
                    // The first address byte ends up lowest.
                    next_r.addr = {lnk.rx_byte, r.addr[31:8]};
                    next_r.cnt = r.cnt + 2'h1;
                    if (r.cnt == `WSPI_ADDR_LAST) begin
                        next_r.st = r.c1[`WSPI_C1_WRITE] ? wspi_pkg::S_WDATA
                                                         : wspi_pkg::S_RWAIT;
                    end
                end
                wspi_pkg::S_WDATA: begin
                    // Each payload byte is passed on in arrival order.
                    next_r.wr_valid = 1'b1;
                    next_r.wr_data = lnk.rx_byte;
                    next_r.len = r.len - 16'h0001;
                    if (r.len == 16'h0001) begin
                        next_r.st = wspi_pkg::S_DROP;
                    end
                end
                wspi_pkg::S_RWAIT: begin
                    // Dummies go out until the source has data, then the token.
                    if (rd_valid_i) begin
                        next_r.tx_hold = `WSPI_TOKEN;
                        next_r.st = wspi_pkg::S_RDATA;
                    end
                end
                wspi_pkg::S_RDATA: begin
                    // An empty source mid-frame yields a dummy byte; the host cannot tell.
                    if (rd_valid_i) begin
                        next_r.tx_hold = rd_data_i;
                        next_r.rd_take = 1'b1;
                    end
                    next_r.len = r.len - 16'h0001;
                    if (r.len == 16'h0001) begin
                        next_r.st = wspi_pkg::S_DROP;
                    end
                end
                wspi_pkg::S_REGR: begin
                    next_r.st = wspi_pkg::S_DROP;
                end
                wspi_pkg::S_REGW: begin
                    // The only register is read-only, so its write data is discarded.
                    next_r.st = wspi_pkg::S_DROP;
                end
                default: begin
                    next_r.st = wspi_pkg::S_DROP;
                end
            endcase
        end
        // The read request pulses once, as the wait for the token begins.
        next_r.rd_req = (next_r.st == wspi_pkg::S_RWAIT) && (r.st != wspi_pkg::S_RWAIT);
    end

    // Single register stage for the whole core state.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.cs_s1 <= 1'b1;
            r.cs_s2 <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign lnk.tx_byte = r.tx_hold;

    wspi_link_phy u_phy (
        .spi_sck_i(spi_sck_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_mosi_i(spi_mosi_i),
        .spi_miso_o(spi_miso_o),
        .lnk(lnk)
    );

    // MISO is driven only while the host selects the device.
    assign spi_miso_oe_o = !spi_cs_n_i;
    assign ready_o = r.inited;
    assign xfer_frame_o = r.c1[`WSPI_C1_FRAME];
    assign xfer_wide_o = (r.c2[`WSPI_C2_MODE_HI:`WSPI_C2_MODE_LO] == `WSPI_MODE_32);
    assign xfer_addr_o = r.addr;
    assign xfer_len_o = r.len;
    assign wr_valid_o = r.wr_valid;
    assign wr_data_o = r.wr_data;
    assign rd_req_o = r.rd_req;
    assign rd_take_o = r.rd_take;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_repeat_init_fail: assert property (evt && r.st == wspi_pkg::S_CMD1 &&
        lnk.rx_byte[7:6] == `WSPI_TYPE_INIT |=> r.tx_hold == `WSPI_ST_FAIL)
        else $error("repeated init not failed");
    a_busy_answer: assert property (evt && r.st == wspi_pkg::S_CMD1 && busy_i &&
        lnk.rx_byte[7:6] == `WSPI_TYPE_RW |=> r.tx_hold == `WSPI_ST_BUSY)
        else $error("busy not answered");
    a_ready_answer: assert property (evt && r.st == wspi_pkg::S_CMD1 && !busy_i &&
        !buf_full_i && lnk.rx_byte[7:6] == `WSPI_TYPE_RW |=> r.tx_hold == `WSPI_ST_READY)
        else $error("ready not answered");
    a_refused_drop: assert property (evt && r.st == wspi_pkg::S_STAT &&
        r.status != `WSPI_ST_READY |=> r.st == wspi_pkg::S_DROP)
        else $error("refused command continued");
    a_token_first: assert property ($rose(r.st == wspi_pkg::S_RDATA) |->
        r.tx_hold == `WSPI_TOKEN && $past(rd_valid_i))
        else $error("data without token");
    a_write_order: assert property ($rose(r.wr_valid) |->
        r.wr_data == $past(lnk.rx_byte) && $past(r.st) == wspi_pkg::S_WDATA)
        else $error("write byte out of order");
    a_status_bits: assert property (evt && r.st == wspi_pkg::S_CMD2 && !r.c1[5] &&
        !r.c1[4] && lnk.rx_byte[5:0] == `WSPI_REG_INTR |=> r.tx_hold[7:4] == 4'h0 &&
        r.tx_hold[3] == $past(pkt_pending_i) && r.tx_hold[0] == $past(buf_full_i))
        else $error("status register value wrong");
    a_frame_no_addr: assert property (evt && r.st == wspi_pkg::S_LENH &&
        r.c1[`WSPI_C1_FRAME] |=> r.st != wspi_pkg::S_ADDR)
        else $error("frame transfer took address");
    a_init_gate: assert property (!r.inited |-> r.st <= wspi_pkg::S_INITD)
        else $error("command state before init");
    a_short_len: assert property (evt && r.st == wspi_pkg::S_STAT &&
        r.status == `WSPI_ST_READY && r.c1[4] && !r.c1[2] && r.c1[1:0] == 2'h0
        |=> r.len == `WSPI_LEN_ZERO4)
        else $error("short length code zero not four");

    c_reg_read: cover property (r.st == wspi_pkg::S_REGR ##1 r.st == wspi_pkg::S_DROP);
    c_frame_write: cover property (r.wr_valid && r.c1[`WSPI_C1_FRAME]);
    c_read_token: cover property ($rose(r.st == wspi_pkg::S_RDATA));
endmodule : wspi_spi_slave

/* test/testbench.sv */
// Self-checking bench of the SPI slave engine, with a host model and an inner data source.
// Assumes the host model file is compiled first and a 100 MHz system clock.
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0; // System clock.
    logic rst_i = 1'b1; // Synchronous reset, held three cycles.
    logic spi_sck_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o; // Link pins.
    logic busy_i = 1'b0, buf_full_i = 1'b0, pkt_pending_i = 1'b0, rd_valid_i = 1'b0;
    logic [7:0] rd_data_i = 8'h00, wr_data_o;
    logic ready_o, xfer_frame_o, xfer_wide_o, wr_valid_o, rd_req_o, rd_take_o, wr_wide, rd_frame;
    logic [31:0] xfer_addr_o, wr_addr, rd_addr;
    logic [15:0] xfer_len_o, rd_len;
    logic [7:0] wr_q[$]; // Payload bytes seen at the inner side.
    logic [7:0] rd_tab[4] = '{8'h3C, 8'h7E, 8'hE1, 8'h00}; // Read source contents.
    int rd_wait = -1, rd_idx = 0, fail_count = 0, total_checks = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    wspi_spi_slave i_dut (.ref_clk_i, .rst_i, .spi_sck_i, .spi_cs_n_i, .spi_mosi_i,
        .spi_miso_o, .spi_miso_oe_o, .busy_i, .buf_full_i, .pkt_pending_i, .ready_o,
        .xfer_frame_o, .xfer_wide_o, .xfer_addr_o, .xfer_len_o, .wr_valid_o, .wr_data_o,
        .rd_req_o, .rd_valid_i, .rd_data_i, .rd_take_o);
    wspi_host_model i_host (.sck_o(spi_sck_i), .cs_n_o(spi_cs_n_i), .mosi_o(spi_mosi_i),
        .miso_i(spi_miso_o));
    // Inner side: logs writes, and serves reads only after a wait so dummies come first.
    always @(negedge ref_clk_i) begin
        if (wr_valid_o === 1'b1) begin
            wr_q.push_back(wr_data_o);
            wr_addr = xfer_addr_o;
            wr_wide = xfer_wide_o;
        end
        if (rd_req_o === 1'b1) begin
            rd_wait = 120;
            rd_idx = 0;
            rd_addr = xfer_addr_o;
            rd_frame = xfer_frame_o;
            rd_len = xfer_len_o;
        end else if (rd_wait > 0) begin
            rd_wait--;
        end
        if (rd_take_o === 1'b1 && rd_idx < 3) begin
            rd_idx++;
        end
        rd_valid_i = (rd_wait == 0) && (rd_idx < 3);
        rd_data_i = rd_tab[rd_idx];
    end
    // Counts one comparison and reports a mismatch at once.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // Commands before init are ignored; a second init and a reserved type both fail.
    task automatic t_init();
        i_host.run_frame({8'h40, 8'h00, 8'h00, 8'h00});
        check("pre-init status", 8'h00, i_host.rx_q[2]);
        check("ready before init", 1'b0, ready_o);
        check("miso enable idle", 1'b0, spi_miso_oe_o);
        i_host.run_frame({8'h12, 8'h4A, 8'h5C, 8'h00});
        check("init answer", 8'h58, i_host.rx_q[3]);
        check("ready after init", 1'b1, ready_o);
        i_host.run_frame({8'h12, 8'h00, 8'h00});
        check("repeat init", 8'h52, i_host.rx_q[2]);
        i_host.run_frame({8'h80, 8'h00, 8'h00});
        check("reserved type", 8'h52, i_host.rx_q[2]);
        $display("test init done");
    endtask : t_init
    // Status register levels, a write to the read-only register, busy and full refusals.
    task automatic t_reg();
        @(negedge ref_clk_i);
        buf_full_i = 1'b1;
        pkt_pending_i = 1'b1;
        wr_q.delete();
        i_host.run_frame({8'h40, 8'h00, 8'h00, 8'h00});
        check("reg read status", 8'h58, i_host.rx_q[2]);
        check("intr both set", 8'h09, i_host.rx_q[3]);
        i_host.run_frame({8'h60, 8'h00, 8'h00, 8'hFF});
        i_host.run_frame({8'h40, 8'h00, 8'h00, 8'h00});
        check("intr after write", 8'h09, i_host.rx_q[3]);
        i_host.run_frame({8'h40, 8'h01, 8'h00, 8'h00});
        check("unmapped reg", 8'h00, i_host.rx_q[3]);
        i_host.run_frame({8'h78, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04});
        check("write while full", 8'h54, i_host.rx_q[2]);
        check("bytes while full", 0, wr_q.size());
        @(negedge ref_clk_i);
        buf_full_i = 1'b0;
        pkt_pending_i = 1'b0;
        busy_i = 1'b1;
        i_host.run_frame({8'h40, 8'h00, 8'h00, 8'h00});
        check("busy answer", 8'h54, i_host.rx_q[2]);
        @(negedge ref_clk_i);
        busy_i = 1'b0;
        i_host.run_frame({8'h40, 8'h00, 8'h00, 8'h00});
        check("intr clear", 8'h00, i_host.rx_q[3]);
        $display("test reg done");
    endtask : t_reg
    // Memory writes with short length codes 0, 1 and 2, then a full check and a descriptor-sized
    // frame write in 32-bit mode.
    task automatic t_write();
        logic [7:0] q[$];
        int n;
        for (int c = 0; c < 4; c++) begin
            wr_q.delete();
            n = (c == 3) ? 16 : (c == 0) ? 4 : c;
            if (c == 3) begin
                // The host sends a descriptor only after the full bit reads clear.
                i_host.run_frame({8'h40, 8'h00, 8'h00, 8'h00});
                check("full before frame", 8'h00, i_host.rx_q[3] & 8'h01);
                q = {8'h7C, 8'h40, 8'h00, 8'h10, 8'h00};
            end else begin
                q = {8'h70 | c[7:0], 8'h00, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44};
            end
            for (int i = 0; i < n; i++) begin
                q.push_back(8'hA0 + i[7:0]);
            end
            i_host.run_frame(q);
            check("write status", 8'h58, i_host.rx_q[2]);
            check("write count", n, wr_q.size());
            foreach (wr_q[i]) check("write byte", 8'hA0 + i, wr_q[i]);
            if (c < 3) check("write addr", 32'h44332211, wr_addr);
        end
        check("wide mode", 1'b1, wr_wide);
        $display("test write done");
    endtask : t_write
    // Long read: dummies, then the start token, then the data lowest index first.
    task automatic t_read(input bit mem);
        logic [7:0] q[$];
        int k;
        q = {mem ? 8'h54 : 8'h5C, 8'h00, 8'h00, 8'h03, 8'h00};
        if (mem) q = {q, 8'h01, 8'h02, 8'h03, 8'h04};
        k = q.size();
        repeat (10) q.push_back(8'h00);
        i_host.run_frame(q);
        check("read status", 8'h58, i_host.rx_q[2]);
        check("read frame flag", !mem, rd_frame);
        check("read length", 3, rd_len);
        if (mem) check("read addr", 32'h04030201, rd_addr);
        check("wait dummy", 8'h00, i_host.rx_q[k]);
        while (k < q.size() - 4 && i_host.rx_q[k] === 8'h00) k++;
        check("start token", 8'h55, i_host.rx_q[k]);
        for (int i = 0; i < 3; i++) check("read byte", rd_tab[i], i_host.rx_q[k + 1 + i]);
        $display("test read done");
    endtask : t_read
    // Main sequence: reset, then every scenario in turn.
    initial begin
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i) rst_i = 1'b0;
        #100;
        t_init();
        t_reg();
        t_write();
        t_read(1'b0);
        t_read(1'b1);
        stop_test();
    end
    // Cuts a hang short after about three times the expected run.
    initial begin
        #200000;
        fail_count++;
        $display("FAIL watchdog expected done seen hang");
        stop_test();
    end
endmodule : testbench

/* test/wspi_host_model.sv */
// Host-side SPI master model: mode 0, 64 ns link clock, one byte queue per frame.
// Assumes the slave samples MOSI on rising edges and updates MISO right after them.
`timescale 1ns/1ps
module wspi_host_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    logic [7:0] rx_q[$]; // Bytes seen on MISO during the last frame.
    logic [7:0] rx_b; // Byte being assembled.
    // The link clock stands low between frames, as a real master leaves it.
    // Chip select starts low and rises after 1 ns. The shifter's asynchronous clear then
    // sees a clean rising edge, whatever order the processes start in at time zero.
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b0;
        mosi_o = 1'b0;
        #1 cs_n_o = 1'b1;
    end
    // Runs one frame; MISO is taken just before each rising edge, where it is settled.
    task automatic run_frame(input logic [7:0] tx[$]);
        rx_q.delete();
        cs_n_o = 1'b0;
        foreach (tx[i]) begin
            for (int b = 7; b >= 0; b--) begin
                mosi_o = tx[i][b];
                #31;
                rx_b[b] = miso_i;
                #1 sck_o = 1'b1;
                #32 sck_o = 1'b0;
            end
            rx_q.push_back(rx_b);
        end
        #32 cs_n_o = 1'b1;
        // Released MOSI shows the inverse of its last bit, so no stale value looks valid.
        mosi_o = ~mosi_o;
        #100;
    endtask : run_frame
endmodule : wspi_host_model
